// ---- src/bank_auto_close.sv ----
`timescale 1ns/100ps
// Summary of operation
// - flag low on read or write leaves the bank open after the burst.
// - flag sampled from command bit 0 at the falling edge; high engages auto close.
// - read auto close starts at max(BL/2, BL/2-2+read-to-close clocks).
// - different-bank reads or writes after auto close may run at BL/2 spacing.
// - close period timed from latest single or all-bank close of that bank.
// - array write starts only after a whole four-word prefetch group.
// - close decoded on rising edge, select low, bits 3..0 = 1,0,1,1.
// - all-bank flag closes every bank not in auto close; else bank bits choose one.
module bank_auto_close
    import bank_close_pkg::*;
#(
    parameter int BURST_LEN = 8,
    parameter int WRITE_LAT = 4
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic                            cs_n,
    input  wire logic [bank_close_pkg::BANK_W+6:0] cmd_addr_rise,
    input  wire logic                            cmd_addr_bit0_falling,
    output logic [bank_close_pkg::NUM_BANKS-1:0] bank_open,
    output logic [bank_close_pkg::NUM_BANKS-1:0] bank_closing,
    output logic [bank_close_pkg::NUM_BANKS-1:0] act_ok,
    output logic                                 array_write_go
);
    import bank_close_pkg::*;

    localparam int HALF_BL   = BURST_LEN / 2;
    localparam int RD_START  = (HALF_BL > HALF_BL - 2 + RTP_CK) ? HALF_BL : HALF_BL - 2 + RTP_CK;
    localparam int WR_START  = WRITE_LAT + HALF_BL + 1 + WR_CK;
    localparam int ROUND_LEN = PREFETCH_WORDS / 2;

    function automatic logic [CNT_W-1:0] ck(input int n);
        return CNT_W'(n);
    endfunction

    ////////////////////////////////////////////////////////////////
    logic                    is_close;
    logic                    is_rd;
    logic                    is_wr;
    logic                    is_act;
    logic [BANK_W-1:0]       bank_sel;
    logic [NUM_BANKS-1:0]    close_hit;
    logic                    cmd_q;
    logic                    rd_q;
    logic                    ap_q;
    logic [BANK_W-1:0]       bank_q;
    logic                    cmd_nxt;

    always_comb begin
        bank_sel = cmd_addr_rise[BA_LSB +: BANK_W];
        is_close = !cs_n && cmd_addr_rise[3:0] == CMD_CLOSE;
        is_rd    = !cs_n && cmd_addr_rise[2:0] == (CMD_READ & CMD_RDWR_MASK);
        is_wr    = !cs_n && cmd_addr_rise[2:0] == (CMD_WRITE & CMD_RDWR_MASK);
        is_act   = !cs_n && cmd_addr_rise[1:0] == CMD_ACT;
        cmd_nxt  = is_rd || is_wr;
        for (int b = 0; b < NUM_BANKS; b++) begin
            close_hit[b] = is_close && (cmd_addr_rise[AB_BIT] || bank_sel == BANK_W'(b));
        end
    end

    // the flag lives on the falling half, so hold the command one cycle and join it there
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_q  <= 1'b0;
            rd_q   <= 1'b0;
            bank_q <= '0;
        end else begin
            cmd_q  <= cmd_nxt;
            rd_q   <= is_rd;
            bank_q <= bank_sel;
        end
    end
    assign ap_q = cmd_addr_bit0_falling;

    ////////////////////////////////////////////////////////////////
    bank_state_t          st_r    [NUM_BANKS];
    bank_state_t          st_nxt  [NUM_BANKS];
    logic [NUM_BANKS-1:0] rc_ok_r;
    logic [NUM_BANKS-1:0] rc_ok_nxt;
    logic [NUM_BANKS-1:0] act_ok_nxt;
    logic [NUM_BANKS-1:0] open_nxt;
    logic [NUM_BANKS-1:0] closing_nxt;

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
        bank_tick_if #(.CNT_W(CNT_W)) dly ();
        bank_tick_if #(.CNT_W(CNT_W)) rc ();
        bank_delay_counter #(.CNT_W(CNT_W)) u_dly (.ref_clk(ref_clk), .rst(rst), .tick(dly));
        bank_delay_counter #(.CNT_W(CNT_W)) u_rc  (.ref_clk(ref_clk), .rst(rst), .tick(rc));

        always_comb begin
            st_nxt[g]      = st_r[g];
            dly.load       = 1'b0;
            dly.value      = '0;
            // an activate to a bank that is not in BK_IDLE must not restart the row cycle
            rc.load        = is_act && bank_sel == BANK_W'(g) && st_r[g] == BK_IDLE;
            rc.value       = ck(RC_CK);
            rc_ok_nxt[g]   = rc_ok_r[g];
            if (rc.load) begin
                rc_ok_nxt[g] = 1'b0;
            end else if (rc.done) begin
                rc_ok_nxt[g] = 1'b1;
            end
            case (st_r[g])
                BK_IDLE: begin
                    if (rc.load) begin
                        st_nxt[g] = BK_OPEN;
                    end else if (close_hit[g]) begin
                        st_nxt[g] = BK_CLOSING;
                        dly.load  = 1'b1;
                        dly.value = cmd_addr_rise[AB_BIT] ? ck(RPAB_CK) : ck(RPPB_CK);
                    end
                end
                BK_OPEN: begin
                    if (close_hit[g]) begin
                        st_nxt[g] = BK_CLOSING;
                        dly.load  = 1'b1;
                        dly.value = cmd_addr_rise[AB_BIT] ? ck(RPAB_CK) : ck(RPPB_CK);
                    end else if (cmd_q && ap_q && bank_q == BANK_W'(g)) begin
                        st_nxt[g] = BK_AUTO;
                        dly.load  = 1'b1;
                        // one cycle spent joining the flag, one more in the done register
                        dly.value = rd_q ? ck(RD_START - 2) : ck(WR_START - 2);
                    end
                    // flag low: bank simply stays open
                end
                BK_AUTO: begin
                    // burst runs to the end; later commands cannot cut it short
                    if (dly.done) begin
                        st_nxt[g] = BK_CLOSING;
                        dly.load  = 1'b1;
                        dly.value = ck(RPPB_CK);
                    end
                end
                BK_CLOSING: begin
                    if (close_hit[g]) begin
                        dly.load  = 1'b1;
                        dly.value = cmd_addr_rise[AB_BIT] ? ck(RPAB_CK) : ck(RPPB_CK);
                    end else if (dly.done) begin
                        st_nxt[g] = BK_IDLE;
                    end
                end
                default: st_nxt[g] = BK_IDLE;
            endcase
            open_nxt[g]    = st_nxt[g] == BK_OPEN || st_nxt[g] == BK_AUTO;
            closing_nxt[g] = st_nxt[g] == BK_AUTO || st_nxt[g] == BK_CLOSING;
            act_ok_nxt[g]  = st_nxt[g] == BK_IDLE && rc_ok_nxt[g];
        end

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                st_r[g] <= BK_IDLE;
            end else begin
                st_r[g] <= st_nxt[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // array write fires once per full four-word group of the latest write burst
    logic [CNT_W-1:0] wr_beat_r;
    logic [CNT_W-1:0] wr_beat_nxt;
    logic [CNT_W-1:0] wr_wait_r;
    logic [CNT_W-1:0] wr_wait_nxt;
    logic             go_nxt;

    always_comb begin
        wr_wait_nxt = wr_wait_r;
        wr_beat_nxt = wr_beat_r;
        go_nxt      = 1'b0;
        if (is_wr) begin
            wr_wait_nxt = ck(WRITE_LAT + 1);
            wr_beat_nxt = ck(HALF_BL);
        end else if (wr_wait_r != '0) begin
            wr_wait_nxt = wr_wait_r - 1'b1;
        end else if (wr_beat_r != '0) begin
            wr_beat_nxt = wr_beat_r - 1'b1;
            go_nxt      = (wr_beat_r - 1'b1) % ck(ROUND_LEN) == '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_wait_r      <= '0;
            wr_beat_r      <= '0;
            array_write_go <= 1'b0;
            rc_ok_r        <= '1;
            bank_open      <= '0;
            bank_closing   <= '0;
            act_ok         <= '1;
        end else begin
            wr_wait_r      <= wr_wait_nxt;
            wr_beat_r      <= wr_beat_nxt;
            array_write_go <= go_nxt;
            rc_ok_r        <= rc_ok_nxt;
            bank_open      <= open_nxt;
            bank_closing   <= closing_nxt;
            act_ok         <= act_ok_nxt;
        end
    end
endmodule

// ---- pkg/bank_close_pkg.sv ----
package bank_close_pkg;
    localparam int          NUM_BANKS        = 8;
    localparam int          BANK_W           = 3;
    localparam int          CNT_W            = 8;
    localparam int          CLK_PERIOD_PS    = 50000;
    // analog times in picoseconds
    localparam int          READ_TO_CLOSE_PS = 7500;
    localparam int          WRITE_REC_PS     = 15000;
    localparam int          CLOSE_PER_PS     = 18000;
    localparam int          CLOSE_ALL_PS     = 21000;
    localparam int          ROW_CYCLE_PS     = 60000;
    // rounded-up clock counts
    localparam int          RTP_CK  = (READ_TO_CLOSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          WR_CK   = (WRITE_REC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          RPPB_CK = (CLOSE_PER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          RPAB_CK = (CLOSE_ALL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          RC_CK   = (ROW_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          PREFETCH_WORDS   = 4;
    // command decode on rising-edge bits 3..0
    localparam logic [3:0]  CMD_CLOSE        = 4'hb;
    localparam logic [2:0]  CMD_RDWR_MASK    = 3'h7;
    localparam logic [2:0]  CMD_READ         = 3'h5;
    localparam logic [2:0]  CMD_WRITE        = 3'h1;
    localparam logic [1:0]  CMD_ACT          = 2'h2;
    localparam int          AB_BIT           = 4;
    localparam int          BA_LSB           = 7;
    typedef enum logic [3:0] {
        BK_IDLE    = 4'h1,
        BK_OPEN    = 4'h2,
        BK_AUTO    = 4'h4,
        BK_CLOSING = 4'h8
    } bank_state_t;
endpackage

// ---- pkg/bank_tick_if.sv ----
`timescale 1ns/100ps
interface bank_tick_if #(parameter int CNT_W = 8);
    logic             load;
    logic [CNT_W-1:0] value;
    logic             done;
    modport ctrl (output load, output value, input done);
    modport cnt  (input load, input value, output done);
endinterface

// ---- src/bank_delay_counter.sv ----
`timescale 1ns/100ps
module bank_delay_counter #(
    parameter int CNT_W = 8
) (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    bank_tick_if.cnt   tick
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             done_r;
    logic             done_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        if (tick.load) begin
            cnt_nxt = tick.value;
        end else if (cnt_r != '0) begin
            cnt_nxt  = cnt_r - 1'b1;
            done_nxt = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign tick.done = done_r;
endmodule

// ---- tb/bank_auto_close_chk.sv ----
`timescale 1ns/100ps
module bank_auto_close_chk
    import bank_close_pkg::*;
#(
    parameter int BURST_LEN = 8,
    parameter int WRITE_LAT = 4
) (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 cs_n,
    input wire logic [BANK_W+6:0]    cmd_addr_rise,
    input wire logic                 cmd_addr_bit0_falling,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic [NUM_BANKS-1:0] bank_closing,
    input wire logic [NUM_BANKS-1:0] act_ok,
    input wire logic                 array_write_go
);
    logic [BANK_W-1:0] ba, rw_ba_r, rw_ba_nxt;
    logic              rd, wr, act, cls;
    logic [7:0]        wr_age_r, wr_age_nxt;
    assign ba  = cmd_addr_rise[BA_LSB +: BANK_W];
    assign rd  = !cs_n && cmd_addr_rise[2:0] == CMD_READ;
    assign wr  = !cs_n && cmd_addr_rise[2:0] == CMD_WRITE;
    assign act = !cs_n && cmd_addr_rise[1:0] == CMD_ACT;
    assign cls = !cs_n && cmd_addr_rise[3:0] == CMD_CLOSE;
    // age saturates so a stray pulse long after any write still fails
    always_comb begin
        rw_ba_nxt  = (rd || wr) ? ba : rw_ba_r;
        wr_age_nxt = wr ? 8'h00 : wr_age_r + {7'h00, wr_age_r != 8'hff};
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rw_ba_r  <= '0;
            wr_age_r <= 8'hff;
        end else begin
            rw_ba_r  <= rw_ba_nxt;
            wr_age_r <= wr_age_nxt;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    chk_act_opens: assert property (
        act && act_ok[ba] |=> bank_open[$past(ba)] && !act_ok[$past(ba)])
        else $error("activate did not open bank");
    chk_close_bank: assert property (
        cls |=> ($past(cmd_addr_rise[AB_BIT]) ? bank_open == '0
                 : !bank_open[$past(ba)] && bank_closing[$past(ba)]))
        else $error("close did not close its banks");
    chk_close_restart: assert property (
        cls |=> ($past(cmd_addr_rise[AB_BIT]) ? act_ok == '0 : !act_ok[$past(ba)]))
        else $error("close period not restarted");
    chk_open_excl: assert property (
        (bank_open & act_ok) == '0)
        else $error("activate allowed on open bank");
    chk_go_pulse: assert property (
        array_write_go |=> !array_write_go)
        else $error("array write pulse too long");
    chk_go_window: assert property (
        array_write_go |-> wr_age_r >= 8'(WRITE_LAT) && wr_age_r <= 8'(WRITE_LAT + BURST_LEN/2 + 2))
        else $error("array write outside write burst");
    chk_rd_keep: assert property (
        rd && bank_open[ba] ##1 !cmd_addr_bit0_falling |-> bank_open[rw_ba_r] [*6])
        else $error("plain read closed its bank");
    chk_rd_auto: assert property (
        rd && bank_open[ba] ##1 cmd_addr_bit0_falling
        |-> (##4 !bank_open[$past(ba, 5)]) or (##5 !bank_open[$past(ba, 6)]))
        else $error("read auto close late");
    chk_wr_auto: assert property (
        wr && bank_open[ba] ##1 cmd_addr_bit0_falling
        |-> bank_open[rw_ba_r] [*8] ##[1:4] !bank_open[rw_ba_r])
        else $error("write auto close mistimed");
endmodule
bind bank_auto_close bank_auto_close_chk #(.BURST_LEN(BURST_LEN), .WRITE_LAT(WRITE_LAT))
    bank_auto_close_chk_inst (.ref_clk, .rst, .cs_n, .cmd_addr_rise, .cmd_addr_bit0_falling,
    .bank_open, .bank_closing, .act_ok, .array_write_go);

// ---- tb/mem_ctrl_model.sv ----
`timescale 1ns/100ps
module mem_ctrl_model
    import bank_close_pkg::*;
#(
    parameter int BL = 8,
    parameter int WL = 4
) (
    input wire logic         ref_clk,
    output logic             cs_n,
    output logic [BANK_W+6:0] cmd_addr_rise,
    output logic             cmd_addr_bit0_falling
);
    localparam int RD_ACT = BL/2 + (RTP_CK > 2 ? RTP_CK : 2) - 2 + RPPB_CK;
    localparam int WR_PRE = WL + BL/2 + WR_CK + 1;
    localparam int WR_ACT = WR_PRE + RPPB_CK;
    initial begin
        cs_n = 1'b1;
        cmd_addr_rise = '0;
        cmd_addr_bit0_falling = 1'b0;
    end
    // deselected cycles carry noise so a stale bus never passes for a command
    task automatic send(input logic [3:0] op, input logic [2:0] ba, input logic ab,
                        input logic flag, input int sp);
        int i;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        cmd_addr_rise <= {ba, 2'($urandom), ab, op};
        @(posedge ref_clk);
        cs_n <= 1'b1;
        cmd_addr_rise <= 10'($urandom);
        cmd_addr_bit0_falling <= flag;
        for (i = 2; i < sp; i++) begin
            @(posedge ref_clk);
            cmd_addr_rise <= 10'($urandom);
            cmd_addr_bit0_falling <= 1'($urandom);
        end
    endtask
endmodule

// ---- tb/bank_auto_close_tb.sv ----
`timescale 1ns/100ps
module bank_auto_close_tb;
    import bank_close_pkg::*;
    localparam int BL = 8;
    localparam int WL = 4;
    logic                 ref_clk, rst, cs_n, cmd_addr_bit0_falling, array_write_go, ap, w;
    logic [BANK_W+6:0]    cmd_addr_rise;
    logic [NUM_BANKS-1:0] bank_open, bank_closing, act_ok, open_exp, seen_r;
    logic [NUM_BANKS-1:0] exp_q[$];
    int                   error_cnt = 0;
    int                   n_checks = 0;
    int                   go_cnt = 0;
    int                   go_exp, i, b;
    bank_auto_close #(.BURST_LEN(BL), .WRITE_LAT(WL)) bank_auto_close_inst (.ref_clk, .rst,
        .cs_n, .cmd_addr_rise, .cmd_addr_bit0_falling, .bank_open, .bank_closing, .act_ok,
        .array_write_go);
    mem_ctrl_model #(.BL(BL), .WL(WL)) mem_ctrl_model_inst (.ref_clk, .cs_n, .cmd_addr_rise,
        .cmd_addr_bit0_falling);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic note(input logic [7:0] v);
        if (v !== open_exp) exp_q.push_back(v);
        open_exp = v;
    endtask
    task automatic drain;
        int k;
        for (k = 0; k < 40 && exp_q.size() > 0; k++) @(posedge ref_clk);
        if (exp_q.size() > 0) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic opn(input int bk);
        note(open_exp | (8'h01 << bk));
        mem_ctrl_model_inst.send({2'($urandom), CMD_ACT}, 3'(bk), 1'b0, 1'b0, 2);
        drain();
    endtask
    task automatic shut(input int bk, input logic ab);
        note(ab ? 8'h00 : open_exp & ~(8'h01 << bk));
        mem_ctrl_model_inst.send(CMD_CLOSE, 3'(bk), ab, 1'b0, 2);
        drain();
        repeat (RPPB_CK + RC_CK) @(posedge ref_clk);
    endtask
    // one-shot sends only: no burst stop, no access to a closing bank
    task automatic rw(input logic wr, input int bk, input logic fl, input int sp);
        if (fl) note(open_exp & ~(8'h01 << bk));
        go_exp += wr ? BL / PREFETCH_WORDS : 0;
        mem_ctrl_model_inst.send({1'($urandom), wr ? CMD_WRITE : CMD_READ}, 3'(bk), 1'b0, fl, sp);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (array_write_go === 1'b1) go_cnt++;
        if (!rst && bank_open !== seen_r)
            check(bank_open, exp_q.size() > 0 ? exp_q.pop_front() : ~bank_open);
        seen_r = bank_open;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        seen_r = '0;
        open_exp = '0;
        go_exp = 0;
        void'($urandom(32'h488f));
        repeat (5) @(posedge ref_clk);
        check(act_ok, 8'hff);
        check(bank_open, 8'h00);
        check(bank_closing | 8'(array_write_go), 8'h00);
        rst <= 1'b0;
        for (i = 0; i < NUM_BANKS; i++) opn(i);
        shut(0, 1'b1);
        shut(0, 1'b1);
        opn(5);
        rw(1'b0, 5, 1'b0, 8);
        drain();
        shut(5, 1'b0);
        opn(2);
        opn(3);
        rw(1'b0, 2, 1'b1, BL/2);
        rw(1'b0, 3, 1'b0, mem_ctrl_model_inst.RD_ACT);
        drain();
        opn(2);
        shut(0, 1'b1);
        opn(6);
        rw(1'b1, 6, 1'b1, mem_ctrl_model_inst.WR_ACT);
        drain();
        opn(6);
        rw(1'b1, 6, 1'b0, mem_ctrl_model_inst.WR_PRE);
        shut(6, 1'b0);
        for (i = 0; i < 12; i++) begin
            b = $urandom % NUM_BANKS;
            ap = 1'($urandom);
            w = 1'($urandom);
            opn(b);
            rw(w, b, ap, w ? mem_ctrl_model_inst.WR_ACT : 8);
            drain();
            if (!ap) shut(b, 1'b0);
        end
        repeat (4) @(posedge ref_clk);
        check(8'(go_cnt), 8'(go_exp));
        tally_and_finish();
    end
endmodule
